// file: ebmm_pkg.sv
/*
 ebmm_pkg: constants and carrier types for the external bus and memory map block.
 assumes a 20 MHz system clock; used by ebmm_bus_unit, ebmm_checker and the test bench.
*/
package ebmm_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] ADDR_TOP = 24'hffffff;
    localparam logic [7:0] BANK_ZERO = 8'h00;
    localparam logic [23:0] PERIPH_LO = 24'h000000;
    localparam logic [23:0] PERIPH_HI = 24'h00007f;
    localparam logic [23:0] RAM_LO = 24'h000080;
    localparam logic [23:0] RAM_HI = 24'h00087f;
    localparam int RAM_BYTES = 2048;
    localparam logic [23:0] VEC_LO = 24'h00ffd6;
    localparam logic [23:0] VEC_HI = 24'h00ffff;
    localparam logic [15:0] DP_BASE_RST = 16'h0000;
    localparam logic [7:0] DP_SPAN = 8'hff;
    localparam logic [15:0] PERIPH_RST = 16'h0000;
    // data phase cycles spent before the synchronised ready level is trusted
    localparam logic [1:0] SYNC_LAG = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_END = 3'b011,
        ST_HOLD = 3'b100
    } ebmm_state_type;

    // request from the core side
    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebmm_req_type;

    // answer back to the core side
    typedef struct packed {
        logic done;
        logic internal;
        logic vector;
        logic [15:0] rdata;
    } ebmm_rsp_type;
endpackage

// file: ebmm_bus_unit.sv
/*
 ebmm_bus_unit: address decode, internal ram and peripheral stand-ins, and the
 multiplexed external bus engine with hold and ready.
 every data phase lasts at least three cycles, so that a device which pulls
 ready low as the strobe falls is seen through the two-flop synchroniser; the
 price is two extra cycles on each external byte part.
 a word on an odd address, or any word on the narrow bus, runs as two byte
 parts under one request; done rises once, after the last part.
 hold is only taken between parts, never inside one.
 assumes the core holds a request stable until done, and that hold, ready and
 bus-width pins are asynchronous to clock.
*/
// How it works
// - byteSel low gives 16-bit bus, high 8-bit
// - strobe low while external transfer happens
// - read/write high for read, low write
// - upper byte enable low on odd address
// - ale marks address phase for external latch
// - accepted hold request drives acknowledge low
// - hold lasts while hold request stays low
// - ready low stretches current access
// - middle group muxes a8-15 with d8-15
// - upper group muxes a16-23 with d0-7
// - low reset input resets the block
// - cpu clock is driven out on pin
// - address space is 24 bits wide
// - top address byte selects 64k bank
// - ram and peripherals live in bank 0
// - ram answers 80 to 87f hex
// - peripheral registers answer 0 to 7f hex
// - vectors fetched externally from ffd6 to ffff
// - direct page window based anywhere bank 0
`timescale 1ns/10ps
module ebmm_bus_unit #(
    parameter int RAM_DEPTH = 2048
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // core side
    input wire ebmm_pkg::ebmm_req_type coreReq,
    input wire logic [7:0] dpOffset,
    input wire logic dpMode,
    input wire logic [15:0] dpBaseWr,
    input wire logic dpBaseWe,
    output ebmm_pkg::ebmm_rsp_type coreRsp,
    output logic [15:0] directPageBase,
    // control pins
    input wire logic byteSel,
    input wire logic holdReq_n,
    input wire logic ready_n,
    output logic strobe_n,
    output logic readWrite,
    output logic upper_byte_en_n,
    output logic addrLatchEn,
    output logic hold_ack_n,
    output logic clockOut,
    // address and multiplexed pins
    output logic [7:0] addrLow,
    input wire logic [7:0] midIn,
    output logic [7:0] midOut,
    output logic midOe,
    input wire logic [7:0] highIn,
    output logic [7:0] highOut,
    output logic highOe
);
    import ebmm_pkg::*;

    // classify an address inside the map
    function automatic logic inRange(input logic [23:0] a, input logic [23:0] lo,
                                     input logic [23:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // sequencer, synchronisers and direct page base
    ebmm_state_type state_q, state_d;
    logic [1:0] byteSync_q, holdSync_q, readySync_q;
    logic [1:0] dwell_q;
    logic [15:0] dpBase_q;

    // internal stores; ram has no reset, contents undefined until written
    logic [7:0] ram_q [RAM_DEPTH];
    logic [7:0] periph_q [128];

    // the external access in flight
    logic [23:0] curAddr_q;
    logic curVec_q;
    logic secondByte_q;

    // registered pins and the core answer
    logic strobe_n_q, readWrite_q, ube_n_q, ale_q, holdAck_n_q, clkOut_q;
    logic [7:0] addrLow_q, midOut_q, highOut_q;
    logic midOe_q, highOe_q;
    logic [15:0] rdata_q;
    logic done_q, internal_q, vector_q;

    // synchronised pin levels
    wire logic busNarrow = byteSync_q[1];
    wire logic holdActive = ~holdSync_q[1];
    wire logic readyLow = ~readySync_q[1];
    // ready is trusted only once the synchroniser lag has passed in the data phase
    wire logic dataDone = (state_q == ST_DATA) && (dwell_q == SYNC_LAG) && !readyLow;

    // effective address: direct page wraps inside bank 0
    wire logic [15:0] dpAddr = dpBase_q + {8'h00, dpOffset};
    wire logic [23:0] effAddr = dpMode ? {BANK_ZERO, dpAddr} : coreReq.addr;
    wire logic [7:0] bankNum = effAddr[23:16];
    wire logic inBank0 = (bankNum == BANK_ZERO);
    wire logic hitRam = inBank0 && inRange(effAddr, RAM_LO, RAM_HI);
    wire logic hitPeriph = inBank0 && inRange(effAddr, PERIPH_LO, PERIPH_HI);
    wire logic hitVector = inRange(effAddr, VEC_LO, VEC_HI);
    wire logic isInternal = hitRam || hitPeriph;
    // byte indices into the internal stores
    wire logic [10:0] ramIdx = 11'(effAddr - RAM_LO);
    wire logic [10:0] ramIdx1 = 11'(effAddr - RAM_LO + 24'h000001);
    wire logic [6:0] perIdx = effAddr[6:0];
    wire logic [6:0] perIdx1 = 7'(effAddr[6:0] + 7'h01);
    wire logic oddAddr = effAddr[0];

    // a word on an odd address or on a narrow bus needs a second byte cycle
    wire logic needSecond = coreReq.wide && (busNarrow || oddAddr);
    // a request starts only once the previous answer has gone
    wire logic startExt = coreReq.valid && !isInternal && !done_q;
    wire logic startInt = coreReq.valid && isInternal && !done_q;
    // byte part now on the bus, and the one the next address phase shows
    wire logic [23:0] cycAddr = secondByte_q ? 24'(curAddr_q + 24'h000001) : curAddr_q;
    wire logic cycOdd = cycAddr[0];
    wire logic [23:0] cycAddrNext = (state_q == ST_IDLE && !secondByte_q) ? effAddr : cycAddr;
    // bytes routed per lane: odd bytes ride the middle group on a wide bus
    wire logic useMid = !busNarrow && (cycOdd || (coreReq.wide && !needSecond));
    wire logic useLow = busNarrow || !cycOdd;
    wire logic [7:0] wrLowByte = secondByte_q ? coreReq.wdata[15:8] : coreReq.wdata[7:0];
    wire logic [7:0] oddByteSrc = (coreReq.wide && !needSecond) ? coreReq.wdata[15:8]
                                  : wrLowByte;
    // only the last part raises done
    wire logic lastPart = !needSecond || secondByte_q;

    // two-flop synchronisers for the asynchronous pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            byteSync_q <= 2'h0;
            holdSync_q <= 2'h3;
            readySync_q <= 2'h3;
        end else begin
            byteSync_q <= {byteSync_q[0], byteSel};
            holdSync_q <= {holdSync_q[0], holdReq_n};
            readySync_q <= {readySync_q[0], ready_n};
        end
    end

    // bus sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (holdActive) begin
                    state_d = ST_HOLD;
                end else if (startExt) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: state_d = ST_DATA;
            ST_DATA: begin
                if (dataDone) begin
                    state_d = ST_END;
                end
            end
            ST_END: state_d = ST_IDLE;
            ST_HOLD: begin
                if (!holdActive) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // state, direct page base and cpu clock out
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            dpBase_q <= DP_BASE_RST;
            clkOut_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (dpBaseWe) begin
                dpBase_q <= dpBaseWr;
            end
            clkOut_q <= ~clkOut_q;
        end
    end

    // data phase dwell: ready crosses two flops, so its level means
    // nothing until the phase has lasted that long
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dwell_q <= 2'h0;
        end else if (state_q != ST_DATA) begin
            dwell_q <= 2'h0;
        end else if (dwell_q != SYNC_LAG) begin
            dwell_q <= dwell_q + 2'h1;
        end
    end

    // latched address and byte phase; the second part must not reload them
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            curAddr_q <= 24'h000000;
            curVec_q <= 1'b0;
            secondByte_q <= 1'b0;
        end else if (state_q == ST_IDLE && startExt && !holdActive && !secondByte_q) begin
            curAddr_q <= effAddr;
            curVec_q <= hitVector;
        end else if (state_q == ST_END) begin
            secondByte_q <= !lastPart;
        end
    end

    // internal memories: ram and peripheral register stand-ins; no reset on ram
    always_ff @(posedge clock) begin
        if (startInt && coreReq.write && hitRam) begin
            ram_q[ramIdx] <= coreReq.wdata[7:0];
            if (coreReq.wide) begin
                ram_q[ramIdx1] <= coreReq.wdata[15:8];
            end
        end
    end

    // peripheral stand-ins clear to zero at reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) begin
                periph_q[i] <= PERIPH_RST[7:0];
            end
        end else if (startInt && coreReq.write && hitPeriph) begin
            periph_q[perIdx] <= coreReq.wdata[7:0];
            if (coreReq.wide) begin
                periph_q[perIdx1] <= coreReq.wdata[15:8];
            end
        end
    end

    // pin drivers: all registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strobe_n_q <= 1'b1;
            readWrite_q <= 1'b1;
            ube_n_q <= 1'b1;
            ale_q <= 1'b0;
            holdAck_n_q <= 1'b1;
            addrLow_q <= 8'h00;
            midOut_q <= 8'h00;
            highOut_q <= 8'h00;
            midOe_q <= 1'b0;
            highOe_q <= 1'b0;
        end else begin
            holdAck_n_q <= !(state_d == ST_HOLD);
            ale_q <= (state_d == ST_ADDR);
            strobe_n_q <= !(state_d == ST_DATA);
            if (state_d == ST_ADDR) begin
                addrLow_q <= cycAddrNext[7:0];
                midOut_q <= cycAddrNext[15:8];
                highOut_q <= cycAddrNext[23:16];
                midOe_q <= 1'b1;
                highOe_q <= 1'b1;
                readWrite_q <= !coreReq.write;
                ube_n_q <= !(cycAddrNext[0] || (coreReq.wide && !busNarrow
                             && !needSecond));
            end else if (state_d == ST_DATA) begin
                midOut_q <= oddByteSrc;
                highOut_q <= wrLowByte;
                midOe_q <= coreReq.write && useMid;
                highOe_q <= coreReq.write && useLow;
            end else begin
                midOe_q <= 1'b0;
                highOe_q <= 1'b0;
                readWrite_q <= 1'b1;
                ube_n_q <= 1'b1;
            end
        end
    end

    // read capture and completion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            done_q <= 1'b0;
            internal_q <= 1'b0;
            vector_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (startInt) begin
                done_q <= 1'b1;
                internal_q <= 1'b1;
                vector_q <= 1'b0;
                rdata_q <= hitRam ? {ram_q[ramIdx1], ram_q[ramIdx]}
                           : {periph_q[perIdx1], periph_q[perIdx]};
            end else if (dataDone) begin
                if (useLow && !secondByte_q) begin
                    rdata_q[7:0] <= highIn;
                end
                if (secondByte_q && busNarrow) begin
                    rdata_q[15:8] <= highIn;
                end
                if (useMid) begin
                    if (cycOdd && !coreReq.wide) begin
                        rdata_q[7:0] <= midIn;
                    end else if (cycOdd && secondByte_q) begin
                        rdata_q[15:8] <= midIn;
                    end else if (cycOdd) begin
                        rdata_q[7:0] <= midIn;
                    end else begin
                        rdata_q[15:8] <= midIn;
                    end
                end
            end else if (state_q == ST_END && lastPart) begin
                done_q <= 1'b1;
                internal_q <= 1'b0;
                vector_q <= curVec_q;
            end
        end
    end

    // outputs straight from flops
    assign strobe_n = strobe_n_q;
    assign readWrite = readWrite_q;
    assign upper_byte_en_n = ube_n_q;
    assign addrLatchEn = ale_q;
    assign hold_ack_n = holdAck_n_q;
    assign clockOut = clkOut_q;

    // data groups and core side answer
    assign addrLow = addrLow_q;
    assign midOut = midOut_q;
    assign midOe = midOe_q;
    assign highOut = highOut_q;
    assign highOe = highOe_q;
    assign directPageBase = dpBase_q;
    assign coreRsp = '{done: done_q, internal: internal_q, vector: vector_q, rdata: rdata_q};
endmodule // ebmm_bus_unit

// file: ebmm_bus_unit_assertions.sv
/*
 ebmm_checker: concurrent checks on the pins of ebmm_bus_unit.
 assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/10ps
module ebmm_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // core side
    input wire ebmm_pkg::ebmm_req_type coreReq,
    input wire logic dpMode,
    input wire ebmm_pkg::ebmm_rsp_type coreRsp,
    // bus pins
    input wire logic holdReq_n,
    input wire logic ready_n,
    input wire logic strobe_n,
    input wire logic readWrite,
    input wire logic upper_byte_en_n,
    input wire logic addrLatchEn,
    input wire logic hold_ack_n,
    input wire logic clockOut,
    input wire logic [7:0] addrLow,
    input wire logic midOe,
    input wire logic highOe
);
    import ebmm_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // address phase, then the strobed data phase of one transfer
    sequence s_addr;
        addrLatchEn && strobe_n;
    endsequence
    sequence s_data;
        !strobe_n && !addrLatchEn;
    endsequence
    // reset check must not be disabled by the reset it watches
    AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n |=> strobe_n && readWrite
        && upper_byte_en_n && !addrLatchEn && hold_ack_n && !midOe && !highOe)
        else $error("pins not idle after reset edge");
    AST_ALE_DATA: assert property (s_addr |-> ##[1:2] s_data)
        else $error("no strobe after address phase");
    AST_ALE_ONE: assert property (addrLatchEn |=> !addrLatchEn)
        else $error("address latch enable longer than one cycle");
    AST_READ_FREE: assert property (!strobe_n && readWrite |-> !midOe && !highOe)
        else $error("data groups driven during read");
    AST_WRITE_DRIVE: assert property (!strobe_n && !readWrite && !addrLow[0] |-> highOe)
        else $error("low data group not driven during write");
    AST_UBE_ODD: assert property (addrLatchEn && addrLow[0] |-> !upper_byte_en_n)
        else $error("upper byte enable high on odd address");
    AST_HOLD_ENTER: assert property ($fell(hold_ack_n) |-> !$past(holdReq_n, 2))
        else $error("hold acknowledge without request");
    AST_HOLD_KEEP: assert property (!hold_ack_n && !holdReq_n && !$past(holdReq_n)
        && !$past(holdReq_n, 2) |=> !hold_ack_n)
        else $error("hold left while request still low");
    AST_HOLD_QUIET: assert property (!hold_ack_n |-> strobe_n && !midOe && !highOe)
        else $error("bus active during hold");
    AST_READY_WAIT: assert property (!strobe_n && !ready_n && !$past(ready_n)
        && !$past(ready_n, 2) |=> !strobe_n)
        else $error("strobe ended while ready held low");
    AST_CLOCK_OUT: assert property (1'b1 |=> $changed(clockOut))
        else $error("clock output stopped");
    AST_INTERNAL: assert property (coreReq.valid && !dpMode && coreReq.addr <= RAM_HI
        |-> !addrLatchEn)
        else $error("external cycle for internal address");
    AST_VECTOR: assert property (coreRsp.done && !dpMode && coreReq.addr >= VEC_LO
        && coreReq.addr <= VEC_HI |-> coreRsp.vector)
        else $error("vector flag missing");
endmodule // ebmm_checker

bind ebmm_bus_unit ebmm_checker u_ebmm_checker (.clock, .rst_n, .coreReq, .dpMode,
    .coreRsp, .holdReq_n, .ready_n, .strobe_n, .readWrite, .upper_byte_en_n,
    .addrLatchEn, .hold_ack_n, .clockOut, .addrLow, .midOe, .highOe);

// file: ebmm_ext_mem.sv
/*
 ebmm_ext_mem: behavioural external memory on the multiplexed bus.
 assumes 256 bytes decoded from A0-7 only; wait length set by the bench.
*/
`timescale 1ns/10ps
module ebmm_ext_mem (
    // clock
    input wire logic clock,
    // control pins from the device
    input wire logic byteSel,
    input wire logic strobe_n,
    input wire logic readWrite,
    input wire logic upper_byte_en_n,
    input wire logic addrLatchEn,
    input wire logic [3:0] waitCycles,
    // address and data groups
    input wire logic [7:0] addrLow,
    input wire logic [7:0] midOut,
    input wire logic [7:0] highOut,
    output logic [7:0] midIn,
    output logic [7:0] highIn,
    output logic ready_n
);
    logic [7:0] mem [256];
    logic [7:0] addrQ = 8'h00;
    logic [7:0] midLast = 8'h00;
    logic [7:0] highLast = 8'h00;
    logic [3:0] waitQ = 4'h0;
    wire reading = !strobe_n && readWrite;
    wire [7:0] evenA = {addrQ[7:1], 1'b0};
    // known pattern that the bench recomputes
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // only the address is taken at ale; wait starts there so the sync lag is covered
    always @(posedge clock) begin
        if (addrLatchEn) begin
            addrQ <= addrLow;
            waitQ <= waitCycles;
        end else if (waitQ != 4'h0) begin
            waitQ <= waitQ - 4'h1;
        end
        if (!strobe_n && !readWrite && byteSel) mem[addrQ] <= highOut;
        if (!strobe_n && !readWrite && !byteSel) begin
            mem[evenA] <= highOut;
            if (!upper_byte_en_n) mem[evenA | 8'h01] <= midOut;
        end
        midLast <= midIn;
        highLast <= highIn;
    end
    // released lines toggle, so a stale value never looks valid
    assign highIn = reading ? mem[byteSel ? addrQ : evenA] : ~highLast;
    assign midIn = (reading && !byteSel) ? mem[evenA | 8'h01] : ~midLast;
    assign ready_n = (waitQ == 4'h0);
endmodule // ebmm_ext_mem

// file: external_bus_and_memory_map_test.sv
/*
 external_bus_and_memory_map_test: self-checking bench for ebmm_bus_unit.
 assumes ebmm_ext_mem on the far side; inputs change at the falling edge.
*/
`timescale 1ns/10ps
module external_bus_and_memory_map_test;
    import ebmm_pkg::*;
    logic clock, rst_n, dpMode, dpBaseWe, byteSel, holdReq_n, ready_n, isInt, isVec;
    logic strobe_n, readWrite, upper_byte_en_n, addrLatchEn, hold_ack_n, clockOut;
    logic midOe, highOe;
    ebmm_req_type coreReq;
    ebmm_rsp_type coreRsp;
    logic [7:0] dpOffset, addrLow, midIn, midOut, highIn, highOut;
    logic [15:0] dpBaseWr, directPageBase, rd;
    logic [23:0] aleAddr;
    logic [3:0] waitCycles;
    int failures, checked, lowCnt, n0;
    ebmm_bus_unit u_ebmm_bus_unit (.clock, .rst_n, .coreReq, .dpOffset, .dpMode, .dpBaseWr,
        .dpBaseWe, .coreRsp, .directPageBase, .byteSel, .holdReq_n, .ready_n, .strobe_n,
        .readWrite, .upper_byte_en_n, .addrLatchEn, .hold_ack_n, .clockOut, .addrLow,
        .midIn, .midOut, .midOe, .highIn, .highOut, .highOe);
    ebmm_ext_mem u_ebmm_ext_mem (.clock, .byteSel, .strobe_n, .readWrite, .upper_byte_en_n,
        .addrLatchEn, .waitCycles, .addrLow, .midOut, .highOut, .midIn, .highIn, .ready_n);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // strobe length and last latched address, seen from the pins
    always @(posedge clock) begin
        if (strobe_n === 1'b0) lowCnt++;
        if (addrLatchEn === 1'b1) aleAddr <= {highOut, midOut, addrLow};
    end
    function automatic logic [15:0] pat2(input logic [7:0] a);
        return {(a + 8'h01) ^ 8'h5a, a ^ 8'h5a};
    endfunction
    task automatic cmpVal(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one wide transfer; request held until done, dropped in the done cycle
    task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] wd);
        int n;
        coreReq = '{valid: 1'b1, write: wr, wide: 1'b1, addr: a, wdata: wd};
        n = 0;
        @(negedge clock);
        while (coreRsp.done !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        cmpVal(coreRsp.done, 1'b1);
        rd = coreRsp.rdata;
        isInt = coreRsp.internal;
        isVec = coreRsp.vector;
        coreReq.valid = 1'b0;
        // an edge passes so the next request never re-raises valid in this step
        @(negedge clock);
    endtask
    task automatic t_internal();
        lowCnt = 0;
        access(1'b1, 24'h000080, 16'h1357);
        access(1'b1, 24'h00007e, 16'h2468);
        access(1'b0, 24'h000080, 16'h0000);
        cmpVal(rd, 16'h1357);
        cmpVal(isInt, 1'b1);
        access(1'b0, 24'h00007e, 16'h0000);
        cmpVal(rd, 16'h2468);
        cmpVal(lowCnt, 0);
    endtask
    task automatic t_ext(input logic narrow);
        byteSel = narrow;
        repeat (4) @(negedge clock);
        access(1'b1, 24'h3400a0 + {narrow, 1'b0}, 16'hbeef);
        access(1'b0, 24'h3400a0 + {narrow, 1'b0}, 16'h0000);
        cmpVal(rd, 16'hbeef);
        access(1'b0, 24'hff0010, 16'h0000);
        cmpVal(rd, pat2(8'h10));
        cmpVal(isInt, 1'b0);
        cmpVal(aleAddr, 24'hff0010 + narrow);
    endtask
    task automatic t_wait();
        byteSel = 1'b0;
        repeat (4) @(negedge clock);
        lowCnt = 0;
        access(1'b0, 24'h050020, 16'h0000);
        n0 = lowCnt;
        waitCycles = 4'h6;
        lowCnt = 0;
        access(1'b0, 24'h050020, 16'h0000);
        cmpVal(rd, pat2(8'h20));
        cmpVal(lowCnt, n0 + 6);
        waitCycles = 4'h0;
    endtask
    task automatic t_hold();
        int n;
        holdReq_n = 1'b0;
        for (n = 0; n < 20 && hold_ack_n !== 1'b0; n++) @(negedge clock);
        cmpVal(hold_ack_n, 1'b0);
        repeat (12) @(negedge clock);
        cmpVal(hold_ack_n, 1'b0);
        holdReq_n = 1'b1;
        for (n = 0; n < 20 && hold_ack_n !== 1'b1; n++) @(negedge clock);
        cmpVal(hold_ack_n, 1'b1);
    endtask
    task automatic t_map();
        dpBaseWr = 16'h1234;
        dpBaseWe = 1'b1;
        @(negedge clock);
        dpBaseWe = 1'b0;
        @(negedge clock);
        cmpVal(directPageBase, 16'h1234);
        dpMode = 1'b1;
        access(1'b0, 24'h000000, 16'h0000);
        cmpVal(aleAddr, 24'h001244);
        cmpVal(rd, pat2(8'h44));
        dpMode = 1'b0;
        access(1'b0, 24'h00fffe, 16'h0000);
        cmpVal({isVec, rd}, {1'b1, pat2(8'hfe)});
    endtask
    task automatic results();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {rst_n, dpMode, dpBaseWe, byteSel, waitCycles, dpOffset, dpBaseWr} = '0;
        coreReq = '0;
        holdReq_n = 1'b1;
        dpOffset = 8'h10;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        cmpVal({strobe_n, readWrite, hold_ack_n, addrLatchEn, highOe}, 5'b11100);
        t_internal();
        t_ext(1'b0);
        t_ext(1'b1);
        t_wait();
        t_hold();
        t_map();
        results();
    end
    // cut a hang well past the expected run length
    initial begin
        #2000000;
        failures++;
        results();
    end
endmodule // external_bus_and_memory_map_test
